// ===== hw/ecmt_event_counter.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "ecmt_map.svh"

// What this block does
// - In counter mode the count advances on edges of the timer input pin, not on clock ticks.
// - The input polarity bit picks rising or falling input edges for counting.
// - In counter mode the prescaler is held off so each counted edge adds exactly one.
// - When the count equals the 16-bit reload value the block flags an interrupt and restarts at 0001H.
// - With the output function enabled the output pin inverts at every reload.
// - The polarity bit sets the output level when the timer is enabled, output used or not.
// - A software count value only governs the first pass; every reload restarts at 0001H.
// - Each counted edge adds one, so until the first reload count minus start equals counted edges since enable.
module ecmt_event_counter (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_tin,
   output logic [7:0] o_rdata,
   output logic o_irq,
   output logic o_tout,
   output logic o_tout_oe_n
);
   import ecmt_pkg::*;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   ecmt_state_s state_ff;
   ecmt_state_s nxt_state;

   // Working terms of the combinational process
   logic sync_agree;
   logic edge_seen;
   logic edge_rising;
   logic edge_counted;
   logic psc_tick;
   logic count_step;
   logic reload_hit;
   logic enable_rise;
   logic [6:0] psc_limit;
   logic wr_ctrl;
   logic wr_cnt_hi;
   logic wr_cnt_lo;
   logic wr_rld_hi;
   logic wr_rld_lo;
   logic wr_stat;
   logic wr_mask;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // Write decode; a write to an unmapped offset is dropped
      wr_ctrl = i_wr && (i_addr == `ECMT_ADDR_CTRL);
      wr_cnt_hi = i_wr && (i_addr == `ECMT_ADDR_CNT_HI);
      wr_cnt_lo = i_wr && (i_addr == `ECMT_ADDR_CNT_LO);
      wr_rld_hi = i_wr && (i_addr == `ECMT_ADDR_RLD_HI);
      wr_rld_lo = i_wr && (i_addr == `ECMT_ADDR_RLD_LO);
      wr_stat = i_wr && (i_addr == `ECMT_ADDR_STAT);
      wr_mask = i_wr && (i_addr == `ECMT_ADDR_MASK);

      // Three-stage synchroniser; stage 0 feeds only stage 1
      nxt_state.sync = {state_ff.sync[1:0], i_tin};

      // A new level is accepted once the last two stages agree
      sync_agree = (state_ff.sync[1] == state_ff.sync[2]);
      edge_seen = sync_agree && (state_ff.sync[2] != state_ff.filt);
      edge_rising = state_ff.sync[2];
      if (edge_seen) begin
         nxt_state.filt = state_ff.sync[2];
      end

      // Polarity 0 counts rising edges, 1 counts falling edges
      edge_counted = edge_seen && (edge_rising != state_ff.pol);

      // ----------------------------------------------------------------
      // Prescaler: divides by 2**pscl in continuous mode only
      // ----------------------------------------------------------------
      psc_limit = 7'((8'h01 << state_ff.pscl) - 8'h01);
      psc_tick = 1'b0;
      if (state_ff.en && (state_ff.mode == ECMT_MODE_CONT)) begin
         if (state_ff.pdiv >= psc_limit) begin
            nxt_state.pdiv = 7'h00;
            psc_tick = 1'b1;
         end else begin
            nxt_state.pdiv = state_ff.pdiv + 7'h01;
         end
      end else begin
         // Held at zero so no divided tick leaks into edge counting
         nxt_state.pdiv = 7'h00;
      end

      // Count source: pin edges in counter mode, divided clock otherwise
      if (state_ff.mode == ECMT_MODE_COUNT) begin
         count_step = state_ff.en && edge_counted;
      end else begin
         count_step = state_ff.en && psc_tick;
      end

      // ----------------------------------------------------------------
      // Counter and reload
      // ----------------------------------------------------------------
      reload_hit = count_step && (state_ff.cnt == state_ff.rld);
      if (reload_hit) begin
         // Restart value is fixed, whatever software loaded first
         nxt_state.cnt = `ECMT_CNT_RESTART;
      end else if (count_step) begin
         nxt_state.cnt = state_ff.cnt + 16'h0001;
      end

      // Software count writes; a write beats a same-cycle step
      if (wr_cnt_hi) begin
         nxt_state.cnt[15:8] = i_wdata;
      end
      if (wr_cnt_lo) begin
         nxt_state.cnt[7:0] = i_wdata;
      end
      if (wr_rld_hi) begin
         nxt_state.rld[15:8] = i_wdata;
      end
      if (wr_rld_lo) begin
         nxt_state.rld[7:0] = i_wdata;
      end

      // ----------------------------------------------------------------
      // Control register and timer output level
      // ----------------------------------------------------------------
      enable_rise = 1'b0;
      if (wr_ctrl) begin
         nxt_state.en = i_wdata[`ECMT_CTRL_EN_BIT];
         nxt_state.mode = ecmt_mode_e'(i_wdata[`ECMT_CTRL_MODE_BIT]);
         nxt_state.pol = i_wdata[`ECMT_CTRL_POL_BIT];
         nxt_state.oen = i_wdata[`ECMT_CTRL_OEN_BIT];
         nxt_state.pscl = i_wdata[`ECMT_CTRL_PSCL_MSB:`ECMT_CTRL_PSCL_LSB];
         enable_rise = i_wdata[`ECMT_CTRL_EN_BIT] && !state_ff.en;
      end

      if (enable_rise) begin
         // Level starts at the polarity bit even with the output unused
         nxt_state.tlvl = i_wdata[`ECMT_CTRL_POL_BIT];
      end else if (reload_hit) begin
         nxt_state.tlvl = !state_ff.tlvl;
      end

      // Pin shows the level only while the output function is on
      nxt_state.tout = nxt_state.oen && nxt_state.tlvl;

      // ----------------------------------------------------------------
      // Interrupt status, mask and request
      // ----------------------------------------------------------------
      if (wr_stat && i_wdata[`ECMT_STAT_RLD_BIT]) begin
         nxt_state.stat = 1'b0;
      end
      // Set placed after clear so a same-cycle reload is not lost
      if (reload_hit) begin
         nxt_state.stat = 1'b1;
      end
      if (wr_mask) begin
         nxt_state.mask = i_wdata[`ECMT_STAT_RLD_BIT];
      end
      nxt_state.irq = nxt_state.stat && nxt_state.mask;

      // ----------------------------------------------------------------
      // Read path, answer one cycle after the strobe
      // ----------------------------------------------------------------
      nxt_state.rdata = 8'h00;
      if (i_rd) begin
         unique case (i_addr)
            `ECMT_ADDR_CTRL: begin
               nxt_state.rdata = {state_ff.en, state_ff.mode, state_ff.pol,
                                  state_ff.oen, 1'b0, state_ff.pscl};
            end
            `ECMT_ADDR_CNT_HI: begin
               // Low byte frozen here so a 16-bit read is coherent if the low-byte read is in the next cycle
               nxt_state.rdata = state_ff.cnt[15:8];
               nxt_state.hold = state_ff.cnt[7:0];
            end
            `ECMT_ADDR_CNT_LO: begin
               nxt_state.rdata = state_ff.hold;
            end
            `ECMT_ADDR_RLD_HI: begin
               nxt_state.rdata = state_ff.rld[15:8];
            end
            `ECMT_ADDR_RLD_LO: begin
               nxt_state.rdata = state_ff.rld[7:0];
            end
            `ECMT_ADDR_STAT: begin
               nxt_state.rdata = {7'h00, state_ff.stat};
            end
            `ECMT_ADDR_MASK: begin
               nxt_state.rdata = {7'h00, state_ff.mask};
            end
            default: begin
               nxt_state.rdata = 8'h00;
            end
         endcase
      end

      // Without a high-byte or low-byte read, the held low byte tracks the live count
      if (!(i_rd && (i_addr == `ECMT_ADDR_CNT_HI))) begin
         if (!(i_rd && (i_addr == `ECMT_ADDR_CNT_LO))) begin
            nxt_state.hold = nxt_state.cnt[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff.sync <= 3'h0;
         state_ff.filt <= 1'b0;
         state_ff.en <= 1'(`ECMT_CTRL_RST >> `ECMT_CTRL_EN_BIT);
         state_ff.mode <= ECMT_MODE_CONT;
         state_ff.pol <= 1'b0;
         state_ff.oen <= 1'b0;
         state_ff.pscl <= 3'h0;
         state_ff.pdiv <= 7'h00;
         state_ff.cnt <= `ECMT_CNT_RST;
         state_ff.rld <= `ECMT_RLD_RST;
         state_ff.hold <= 8'h00;
         state_ff.tlvl <= 1'b0;
         state_ff.stat <= `ECMT_STAT_RST;
         state_ff.mask <= `ECMT_MASK_RST;
         state_ff.rdata <= 8'h00;
         state_ff.irq <= 1'b0;
         state_ff.tout <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, each a flip-flop of the state
   // ----------------------------------------------------------------------
   assign o_rdata = state_ff.rdata;
   assign o_irq = state_ff.irq;
   assign o_tout = state_ff.tout;
   assign o_tout_oe_n = !state_ff.oen;

endmodule

// ===== hw/ecmt_map.svh
`ifndef ECMT_MAP_SVH
`define ECMT_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ECMT_ADDR_CTRL 8'h00
`define ECMT_ADDR_CNT_HI 8'h01
`define ECMT_ADDR_CNT_LO 8'h02
`define ECMT_ADDR_RLD_HI 8'h03
`define ECMT_ADDR_RLD_LO 8'h04
`define ECMT_ADDR_STAT 8'h05
`define ECMT_ADDR_MASK 8'h06

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ECMT_CTRL_EN_BIT 7
`define ECMT_CTRL_MODE_BIT 6
`define ECMT_CTRL_POL_BIT 5
`define ECMT_CTRL_OEN_BIT 4
`define ECMT_CTRL_PSCL_MSB 2
`define ECMT_CTRL_PSCL_LSB 0

// ----------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------
`define ECMT_STAT_RLD_BIT 0

// ----------------------------------------------------------------------
// Reset values and count constants
// ----------------------------------------------------------------------
`define ECMT_CTRL_RST 8'h00
`define ECMT_CNT_RST 16'h0000
`define ECMT_RLD_RST 16'h0000
`define ECMT_STAT_RST 1'b0
`define ECMT_MASK_RST 1'b0
`define ECMT_CNT_RESTART 16'h0001
`define ECMT_SYNC_STAGES 3

`endif

// ===== hw/ecmt_pkg.sv
package ecmt_pkg;

   typedef enum logic [0:0] {
      ECMT_MODE_CONT = 1'b0,
      ECMT_MODE_COUNT = 1'b1
   } ecmt_mode_e;

   typedef struct packed {
      logic [2:0] sync;
      logic filt;
      logic en;
      ecmt_mode_e mode;
      logic pol;
      logic oen;
      logic [2:0] pscl;
      logic [6:0] pdiv;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0] hold;
      logic tlvl;
      logic stat;
      logic mask;
      logic [7:0] rdata;
      logic irq;
      logic tout;
   } ecmt_state_s;

endpackage

// ===== tb/ecmt_event_counter_sva.sv
`timescale 1ns/10ps
module ecmt_event_counter_sva (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_tin,
   input wire logic [7:0] o_rdata,
   input wire logic o_irq,
   input wire logic o_tout,
   input wire logic o_tout_oe_n
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // ----
   // Quiet-time counters, with the previous input and an enable shadow
   // ----
   logic tp_ff;
   logic en_ff;
   logic [3:0] tq_ff;
   logic [3:0] wq_ff;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         tp_ff <= 1'b0;
         en_ff <= 1'b0;
         tq_ff <= 4'h0;
         wq_ff <= 4'h0;
      end else begin
         tp_ff <= i_tin;
         en_ff <= (i_wr && i_addr == 8'h00) ? i_wdata[7] : en_ff;
         tq_ff <= (i_tin != tp_ff) ? 4'h0 : tq_ff + {3'h0, tq_ff != 4'hF};
         wq_ff <= i_wr ? 4'h0 : wq_ff + {3'h0, wq_ff != 4'hF};
      end
   end
   a_rd_unmapped: assert property (i_rd && i_addr > 8'h06 |=> o_rdata == 8'h00)
      else $error("unmapped read gave data");
   a_tout_gated: assert property (o_tout_oe_n |-> !o_tout)
      else $error("output high while not driven");
   a_oe_follow: assert property (i_wr && i_addr == 8'h00 |->
      ##2 o_tout_oe_n == !$past(i_wdata[4], 2))
      else $error("output enable does not follow control");
   a_tout_init: assert property (i_wr && i_addr == 8'h00 && i_wdata[7] && i_wdata[4] && !en_ff
      && tq_ff >= 4'h8 |-> ##2 o_tout == $past(i_wdata[5], 2))
      else $error("initial output level not the polarity");
   a_irq_w1c: assert property (i_wr && i_addr == 8'h05 && i_wdata[0] && tq_ff >= 4'h8
      |-> ##2 !o_irq)
      else $error("interrupt not cleared");
   a_mask_off: assert property (i_wr && i_addr == 8'h06 && !i_wdata[0] |-> ##2 !o_irq)
      else $error("masked interrupt still high");
   a_irq_cause: assert property ($rose(o_irq) |-> tq_ff < 4'h8 || wq_ff < 4'h3)
      else $error("interrupt without input edge");
   a_tout_cause: assert property ($changed(o_tout) |-> tq_ff < 4'h8 || wq_ff < 4'h3)
      else $error("output toggled without input edge");
   c_irq: cover property ($rose(o_irq));
   c_toggle: cover property ($changed(o_tout) && !o_tout_oe_n);
   c_cnt_read: cover property (i_rd && i_addr == 8'h01);
endmodule

bind ecmt_event_counter ecmt_event_counter_sva u_ecmt_event_counter_sva (.i_clk_sys(i_clk_sys),
   .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .i_tin(i_tin), .o_rdata(o_rdata), .o_irq(o_irq), .o_tout(o_tout),
   .o_tout_oe_n(o_tout_oe_n));

// ===== tb/ecmt_tin_src.sv
`timescale 1ns/10ps
module ecmt_tin_src (
   input wire logic i_clk_sys,
   input wire logic i_go,
   input wire logic [7:0] i_tog,
   input wire logic [2:0] i_gap,
   output logic o_tin = 1'b0,
   output logic o_busy
);
   logic [7:0] left = 8'h00;
   logic [2:0] hold = 3'h0;
   assign o_busy = left != 8'h00;
   always @(posedge i_clk_sys) begin
      if (i_go) begin
         left <= i_tog;
      end else if (hold != 3'h0) begin
         hold <= hold - 3'h1;
      end else if (o_busy) begin
         o_tin <= ~o_tin;
         left <= left - 8'h01;
         // Two stable cycles at least keeps the rate at a quarter clock
         hold <= (i_gap == 3'h0) ? 3'h1 : i_gap;
      end
   end
endmodule

// ===== tb/tb_ecmt_event_counter.sv
`timescale 1ns/10ps
module tb_ecmt_event_counter;
   logic i_clk_sys, i_nrst, i_wr, i_rd, go, busy, tin, o_irq, o_tout, o_tout_oe_n, lvl, m;
   logic [7:0] i_addr, i_wdata, tog, o_rdata, d;
   logic [2:0] gap;
   logic [15:0] cnt, rld;
   logic [31:0] seed;
   int num_errors, comparisons, hits;
   ecmt_event_counter u_ecmt_event_counter (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_tin(tin),
      .o_rdata(o_rdata), .o_irq(o_irq), .o_tout(o_tout), .o_tout_oe_n(o_tout_oe_n));
   ecmt_tin_src u_ecmt_tin_src (.i_clk_sys(i_clk_sys), .i_go(go), .i_tog(tog), .i_gap(gap),
      .o_tin(tin), .o_busy(busy));
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] nxt(input logic [15:0] c, input logic [15:0] r);
      return (c == r) ? 16'h0001 : c + 16'h0001;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
   endtask
   task automatic chk_cnt();
      logic [7:0] h;
      logic [7:0] l;
      rd(8'h01, h);
      rd(8'h02, l);
      check({h, l}, cnt);
   endtask
   // Each edge is two toggles, so the line always comes back low
   task automatic edges(input int n, input logic en);
      seed = xs(seed);
      @(posedge i_clk_sys);
      tog <= 8'(2 * n);
      gap <= {1'b0, seed[1:0]};
      go <= 1'b1;
      @(posedge i_clk_sys);
      go <= 1'b0;
      for (int i = 0; i <= 2000; i++) begin
         if (i == 2000) begin
            num_errors++;
            close_out();
         end
         @(posedge i_clk_sys);
         #1;
         if (!busy) break;
      end
      repeat (6) @(posedge i_clk_sys);
      for (int k = 0; k < n && en; k++) begin
         hits += int'(cnt == rld);
         lvl ^= (cnt == rld);
         cnt = nxt(cnt, rld);
      end
   endtask
   initial begin
      {i_nrst, i_wr, i_rd, go, i_addr, i_wdata, tog, gap} = '0;
      seed = 32'd94767;
      num_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      wr(8'h07, 8'hFF);
      for (int a = 0; a < 8; a++) begin
         rd(8'(a), d);
         check({8'h00, d}, 16'h0000);
      end
      $display("test reset values done");
      for (int r = 0; r < 8; r++) begin
         seed = xs(seed);
         rld = {12'h000, seed[3:0]} + 16'h0002;
         cnt = (r < 2) ? 16'h0001 : 16'h0001 + ({8'h00, seed[15:8]} % rld);
         lvl = seed[4];
         m = seed[5];
         hits = 0;
         wr(8'h00, {2'b01, lvl, 5'h00});
         wr(8'h01, cnt[15:8]);
         wr(8'h02, cnt[7:0]);
         wr(8'h03, rld[15:8]);
         wr(8'h04, rld[7:0]);
         wr(8'h05, 8'h01);
         wr(8'h06, {7'h00, m});
         wr(8'h00, {2'b11, lvl, 2'b10, seed[8:6]});
         repeat (3) @(posedge i_clk_sys);
         check({15'h0, o_tout}, {15'h0, lvl});
         check({15'h0, o_tout_oe_n}, 16'h0000);
         repeat (2) begin
            seed = xs(seed);
            edges(int'(seed[4:0]) % (2 * int'(rld) + 1), 1'b1);
            chk_cnt();
            check({15'h0, o_tout}, {15'h0, lvl});
            check({15'h0, o_irq}, {15'h0, m && hits > 0});
         end
         rd(8'h05, d);
         check({8'h00, d}, {15'h0, hits > 0});
         wr(8'h05, 8'h01);
         rd(8'h05, d);
         check({o_irq, d}, 9'h000);
         wr(8'h00, {2'b01, lvl, 5'h10});
         edges(3, 1'b0);
         chk_cnt();
         $display("test round %0d done", r);
      end
      close_out();
   end
endmodule
